// *** rtl/rvp_defs.svh ***
/*
 * Offsets, field positions, reset values and timing figures of the video
 * input port. Assumes inclusion by bare name from files under rtl/.
 */
`ifndef RVP_DEFS_SVH
`define RVP_DEFS_SVH

`define RVP_CLK_HZ            40000000
`define RVP_H_PIX             240
`define RVP_DISP_LINES        320
`define RVP_FRAME_HZ          60
`define RVP_CLKS_PER_LINE     41
`define RVP_FRONT_PORCH       12
`define RVP_NOM_BACK_PORCH    14
`define RVP_OSC_DIV           (`RVP_CLK_HZ / (`RVP_FRAME_HZ * (`RVP_DISP_LINES + \
                              `RVP_FRONT_PORCH + `RVP_NOM_BACK_PORCH) * `RVP_CLKS_PER_LINE))

`define RVP_OFS_CTRL          8'h00
`define RVP_OFS_PORCH         8'h04
`define RVP_OFS_RGB_XWIN      8'h08
`define RVP_OFS_RGB_YWIN      8'h0C
`define RVP_OFS_CPU_XWIN      8'h10
`define RVP_OFS_CPU_YWIN      8'h14
`define RVP_OFS_CPU_ADDR      8'h18
`define RVP_OFS_RAM_DATA      8'h1C
`define RVP_OFS_STATUS        8'h20
`define RVP_OFS_POS           8'h24
`define RVP_OFS_SCAN          8'h28

`define RVP_CTRL_RAS          0
`define RVP_CTRL_DOS_LO       1
`define RVP_CTRL_WID_LO       3
`define RVP_CTRL_HS_POL       5
`define RVP_CTRL_VS_POL       6
`define RVP_CTRL_DOT_POL      7
`define RVP_CTRL_HSW          8
`define RVP_PORCH_VBP_LO      4
`define RVP_WIN_HI_LO         16
`define RVP_STAT_REFUSED      4

`define RVP_CTRL_RST          32'h0000_0000
`define RVP_PORCH_RST         32'h0000_0001
`define RVP_XWIN_RST          32'h00EF_0000
`define RVP_YWIN_RST          32'h013F_0000

`endif

// *** rtl/rvp_pkg.sv ***
/*
 * Types shared by the video input port files.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package rvp_pkg;

   typedef enum logic [1:0] {
      RVP_OP_INTERNAL = 2'b00,
      RVP_OP_VIDEO    = 2'b01,
      RVP_OP_VSYNC    = 2'b10,
      RVP_OP_BAD      = 2'b11
   } rvp_opmode_t;

   typedef enum logic [1:0] {
      RVP_W18 = 2'b00,
      RVP_W16 = 2'b01,
      RVP_W6  = 2'b10,
      RVP_WBAD = 2'b11
   } rvp_width_t;

endpackage

// *** rtl/rvp_port.sv ***
/*
 * Video input port with frame RAM, CPU RAM path and internal scan timing.
 * Assumes an Avalon-MM master on clk and video pins asynchronous to clk.
 */
// Summary of operation
// - Video pixels accepted only with ram select 1 and display mode 01.
// - Hsync and vsync give line and frame sync; pixels latch on dot clock.
// - In capture mode each active dot clock edge after the back porch writes one pixel; 6-bit mode takes three edges per pixel.
// - X pointer clears on hsync and counts dot clock pixel strobes.
// - Y pointer clears on vsync and counts line sync pulses.
// - Blanking lengths come from horizontal and vertical back porch fields.
// - Hsync, vsync and dot clock polarity are each programmable.
// - Video writes land only inside the video window, gated by window enable.
// - While video runs, register writes other than CPU window and address work but CPU RAM access does not.
// - CPU RAM writes go to the CPU window area.
// - High-speed RAM write is unavailable in video mode.
// - CPU address and CPU window registers are ignored in video mode.
// - Ram select 0 with display mode 10 selects vsync-locked mode.
// - In vsync-locked mode vsync restarts the internal scan; RAM via CPU.
// - Internal oscillator rate follows frame rate, lines, porches, line clocks.
// - Width select 00 18-bit, 01 16-bit, 10 6-bit, 11 prohibited.
// - Display mode 00 internal, 01 video, 10 vsync-locked, 11 prohibited.
// - 16-bit mode fills red and blue LSBs from their MSBs.
// - 6-bit mode builds a pixel from red, green, blue transfers.
`timescale 1ns/1ps
`default_nettype none
`include "rvp_defs.svh"

module rvp_port
   import rvp_pkg::*;
#(
   parameter int H_PIX      = `RVP_H_PIX,
   parameter int DISP_LINES = `RVP_DISP_LINES,
   parameter int LINE_CLKS  = `RVP_CLKS_PER_LINE,
   parameter int FRONT_PORCH = `RVP_FRONT_PORCH,
   parameter int OSC_DIV    = `RVP_OSC_DIV
)(
   // Clock and reset.
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // Avalon-MM register slave.
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   // Video port pins.
   input  wire logic        hsync,
   input  wire logic        vsync,
   input  wire logic        dot_clock,
   input  wire logic        valid_window_enable,
   input  wire logic [5:0]  rgb_red,
   input  wire logic [5:0]  rgb_green,
   input  wire logic [5:0]  rgb_blue,
   // Status.
   output logic             video_active
);

   localparam int AW = $clog2(H_PIX * DISP_LINES);

   function automatic logic [AW-1:0] pix_addr(input logic [7:0] x, input logic [8:0] y);
      pix_addr = AW'(y * H_PIX + x);
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be);
      for (int i = 0; i < 4; i++) begin
         merge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Register file.

   logic [31:0] ctrl_r, porch_r, rgb_xwin_r, rgb_ywin_r, cpu_xwin_r, cpu_ywin_r;
   logic [7:0]  cpu_x_r;
   logic [8:0]  cpu_y_r;
   logic        refused_r;
   logic        wr_now, rd_now;
   logic        video_mode_r, vs_mode_r, bad_mode_r;
   rvp_opmode_t dos;
   rvp_width_t  wid;
   logic [17:0] ram [0:H_PIX*DISP_LINES-1];

   assign wr_now = avs_write & ~avs_waitrequest;
   assign rd_now = avs_read & ~avs_waitrequest;
   assign dos = rvp_opmode_t'(ctrl_r[`RVP_CTRL_DOS_LO +: 2]);
   assign wid = rvp_width_t'(ctrl_r[`RVP_CTRL_WID_LO +: 2]);

   // Each request is answered one edge after it is seen.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= ~avs_waitrequest | ~(avs_read | avs_write);
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl_r     <= `RVP_CTRL_RST;
         porch_r    <= `RVP_PORCH_RST;
         rgb_xwin_r <= `RVP_XWIN_RST;
         rgb_ywin_r <= `RVP_YWIN_RST;
      end else if (wr_now) begin
         unique case (avs_address)
            `RVP_OFS_CTRL:     ctrl_r     <= merge(ctrl_r, avs_writedata, avs_byteenable);
            `RVP_OFS_PORCH:    porch_r    <= merge(porch_r, avs_writedata, avs_byteenable);
            `RVP_OFS_RGB_XWIN: rgb_xwin_r <= merge(rgb_xwin_r, avs_writedata, avs_byteenable);
            `RVP_OFS_RGB_YWIN: rgb_ywin_r <= merge(rgb_ywin_r, avs_writedata, avs_byteenable);
            default: ;
         endcase
      end
   end

   // CPU window and address setup; writes here are dropped in video mode.
   logic cpu_ram_wr;
   assign cpu_ram_wr = wr_now && avs_address == `RVP_OFS_RAM_DATA && !video_mode_r;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cpu_xwin_r <= `RVP_XWIN_RST;
         cpu_ywin_r <= `RVP_YWIN_RST;
         cpu_x_r    <= 8'h00;
         cpu_y_r    <= 9'h000;
      end else if (wr_now && !video_mode_r) begin
         if (avs_address == `RVP_OFS_CPU_XWIN) begin
            cpu_xwin_r <= merge(cpu_xwin_r, avs_writedata, avs_byteenable);
         end
         if (avs_address == `RVP_OFS_CPU_YWIN) begin
            cpu_ywin_r <= merge(cpu_ywin_r, avs_writedata, avs_byteenable);
         end
         if (avs_address == `RVP_OFS_CPU_ADDR) begin
            cpu_x_r <= avs_writedata[7:0];
            cpu_y_r <= avs_writedata[`RVP_WIN_HI_LO +: 9];
         end
         // Data writes walk the CPU window row by row and wrap to its start.
         if (cpu_ram_wr) begin
            if (cpu_x_r == cpu_xwin_r[`RVP_WIN_HI_LO +: 8]) begin
               cpu_x_r <= cpu_xwin_r[7:0];
               cpu_y_r <= (cpu_y_r == cpu_ywin_r[`RVP_WIN_HI_LO +: 9]) ?
                          cpu_ywin_r[8:0] : cpu_y_r + 9'h001;
            end else begin
               cpu_x_r <= cpu_x_r + 8'h01;
            end
         end
      end
   end

   // A refused CPU RAM access is remembered; a new refusal beats the clear.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         refused_r <= 1'b0;
      end else if ((wr_now || rd_now) && avs_address == `RVP_OFS_RAM_DATA && video_mode_r) begin
         refused_r <= 1'b1;
      end else if (wr_now && avs_address == `RVP_OFS_STATUS && avs_byteenable[0] &&
                   avs_writedata[`RVP_STAT_REFUSED]) begin
         refused_r <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         video_mode_r <= 1'b0;
         vs_mode_r    <= 1'b0;
         bad_mode_r   <= 1'b0;
         video_active <= 1'b0;
      end else begin
         video_mode_r <= ctrl_r[`RVP_CTRL_RAS] && dos == RVP_OP_VIDEO && wid != RVP_WBAD;
         vs_mode_r    <= !ctrl_r[`RVP_CTRL_RAS] && dos == RVP_OP_VSYNC;
         bad_mode_r   <= dos == RVP_OP_BAD || wid == RVP_WBAD;
         video_active <= video_mode_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Video pins: synchronise, correct polarity, find active edges.

   logic [21:0] pin_lvl, pin_lead;
   logic        hs_edge, vs_edge, dot_edge, vld;
   logic [5:0]  px_r6, px_g6, px_b6;

   rvp_sync #(.W(22)) u_sync (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .async_in ({rgb_red, rgb_green, rgb_blue, valid_window_enable, dot_clock, vsync, hsync}),
      .invert   ({19'h00000, ctrl_r[`RVP_CTRL_DOT_POL], ctrl_r[`RVP_CTRL_VS_POL],
                  ctrl_r[`RVP_CTRL_HS_POL]}),
      .level    (pin_lvl),
      .lead     (pin_lead)
   );

   assign hs_edge  = pin_lead[0];
   assign vs_edge  = pin_lead[1];
   assign dot_edge = pin_lead[2];
   assign vld      = pin_lvl[3];
   assign px_b6    = pin_lvl[9:4];
   assign px_g6    = pin_lvl[15:10];
   assign px_r6    = pin_lvl[21:16];

   ////////////////////////////////////////////////////////////////////////////
   // Capture pointers and porch skipping.

   logic [7:0]  x_r;
   logic [8:0]  y_r;
   logic [3:0]  hskip_r, vskip_r;
   logic        line_on_r;
   logic [1:0]  phase_r;
   logic [11:0] part_r;
   logic        pix_we_r;
   logic [AW-1:0] pix_addr_r;
   logic [17:0] pix_data_r;
   logic [17:0] pix_nxt;
   logic        pix_done;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         y_r       <= 9'h000;
         vskip_r   <= 4'h0;
         line_on_r <= 1'b0;
      end else if (vs_edge) begin
         y_r       <= 9'h000;
         vskip_r   <= porch_r[`RVP_PORCH_VBP_LO +: 4];
         line_on_r <= 1'b0;
      end else if (hs_edge) begin
         if (vskip_r != 4'h0) begin
            vskip_r <= vskip_r - 4'h1;
         end else if (line_on_r) begin
            y_r <= y_r + 9'h001;
         end else begin
            line_on_r <= 1'b1;
         end
      end
   end

   // Pixel assembly for each bus width.
   always_comb begin
      pix_nxt  = {px_r6, px_g6, px_b6};
      pix_done = 1'b1;
      unique case (wid)
         RVP_W18: ;
         RVP_W16: pix_nxt = {px_r6[5:1], px_r6[5], px_g6, px_b6[5:1], px_b6[5]};
         RVP_W6: begin
            pix_nxt  = {part_r, px_r6};
            pix_done = phase_r == 2'd2;
         end
         RVP_WBAD: pix_done = 1'b0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         x_r     <= 8'h00;
         hskip_r <= 4'h0;
         phase_r <= 2'd0;
         part_r  <= 12'h000;
      end else if (hs_edge) begin
         x_r     <= 8'h00;
         hskip_r <= porch_r[3:0];
         phase_r <= 2'd0;
      end else if (dot_edge && video_mode_r) begin
         if (hskip_r != 4'h0) begin
            hskip_r <= hskip_r - 4'h1;
         end else if (wid == RVP_W6 && phase_r != 2'd2) begin
            phase_r <= phase_r + 2'd1;
            part_r  <= {part_r[5:0], px_r6};
         end else begin
            phase_r <= 2'd0;
            if (x_r != 8'hFF) begin
               x_r <= x_r + 8'h01;
            end
         end
      end
   end

   // Window check on both axes, gated by the enable pin.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pix_we_r   <= 1'b0;
         pix_addr_r <= '0;
         pix_data_r <= 18'h00000;
      end else begin
         pix_we_r <= dot_edge && video_mode_r && !bad_mode_r && pix_done &&
                     hskip_r == 4'h0 && line_on_r && vld &&
                     x_r >= rgb_xwin_r[7:0] && x_r <= rgb_xwin_r[`RVP_WIN_HI_LO +: 8] &&
                     y_r >= rgb_ywin_r[8:0] && y_r <= rgb_ywin_r[`RVP_WIN_HI_LO +: 9] &&
                     x_r < 8'(H_PIX) && y_r < 9'(DISP_LINES);
         pix_addr_r <= pix_addr(x_r, y_r);
         pix_data_r <= pix_nxt;
      end
   end

   // The frame RAM keeps its contents across reset.
   always_ff @(posedge clk) begin
      if (pix_we_r) begin
         ram[pix_addr_r] <= pix_data_r;
      end else if (cpu_ram_wr && cpu_x_r < 8'(H_PIX) && cpu_y_r < 9'(DISP_LINES)) begin
         ram[pix_addr(cpu_x_r, cpu_y_r)] <= avs_writedata[17:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Internal scan timing from the built-in oscillator.

   logic [15:0] osc_r;
   logic [7:0]  lclk_r;
   logic [9:0]  scan_r;
   logic [9:0]  scan_total;

   // Frame length in lines; the divider sets the line rate.
   assign scan_total = 10'(DISP_LINES + FRONT_PORCH) + 10'(porch_r[`RVP_PORCH_VBP_LO +: 4]);

   always_ff @(posedge clk) begin
      if (sys_rst || (vs_mode_r && vs_edge)) begin
         osc_r  <= 16'h0000;
         lclk_r <= 8'h00;
         scan_r <= 10'h000;
      end else if (osc_r == 16'(OSC_DIV - 1)) begin
         osc_r <= 16'h0000;
         if (lclk_r == 8'(LINE_CLKS - 1)) begin
            lclk_r <= 8'h00;
            scan_r <= (scan_r == scan_total - 10'h001) ? 10'h000 : scan_r + 10'h001;
         end else begin
            lclk_r <= lclk_r + 8'h01;
         end
      end else begin
         osc_r <= osc_r + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data.

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         avs_readdata <= 32'h0000_0000;
      end else if (avs_read && avs_waitrequest) begin
         unique case (avs_address)
            `RVP_OFS_CTRL:     avs_readdata <= {23'h000000, ctrl_r[8:0]};
            `RVP_OFS_PORCH:    avs_readdata <= {24'h000000, porch_r[7:0]};
            `RVP_OFS_RGB_XWIN: avs_readdata <= rgb_xwin_r & 32'h00FF_00FF;
            `RVP_OFS_RGB_YWIN: avs_readdata <= rgb_ywin_r & 32'h01FF_01FF;
            `RVP_OFS_CPU_XWIN: avs_readdata <= cpu_xwin_r & 32'h00FF_00FF;
            `RVP_OFS_CPU_YWIN: avs_readdata <= cpu_ywin_r & 32'h01FF_01FF;
            `RVP_OFS_CPU_ADDR: avs_readdata <= {7'h00, cpu_y_r, 8'h00, cpu_x_r};
            `RVP_OFS_RAM_DATA: avs_readdata <= (video_mode_r || cpu_x_r >= 8'(H_PIX) ||
                                                cpu_y_r >= 9'(DISP_LINES)) ? 32'h0 :
                                               {14'h0000, ram[pix_addr(cpu_x_r, cpu_y_r)]};
            `RVP_OFS_STATUS:   avs_readdata <= {26'h0000000, vld, refused_r,
                                                ctrl_r[`RVP_CTRL_HSW] & ~video_mode_r,
                                                bad_mode_r, vs_mode_r, video_mode_r};
            `RVP_OFS_POS:      avs_readdata <= {7'h00, y_r, 8'h00, x_r};
            `RVP_OFS_SCAN:     avs_readdata <= {22'h000000, scan_r};
            default:           avs_readdata <= 32'h0000_0000;
         endcase
      end
   end

endmodule

`default_nettype wire

// *** rtl/rvp_sync.sv ***
/*
 * Two-flop synchroniser with polarity correction and active-edge detection.
 * Assumes the inputs are asynchronous to clk and change slowly against it.
 */
`timescale 1ns/1ps
`default_nettype none

module rvp_sync #(
   parameter int W = 4
)(
   // Clock and reset.
   input  wire logic         clk,
   input  wire logic         sys_rst,
   // Asynchronous inputs and their polarity.
   input  wire logic [W-1:0] async_in,
   input  wire logic [W-1:0] invert,
   // Synchronised results.
   output logic      [W-1:0] level,
   output logic      [W-1:0] lead
);

   logic [W-1:0] meta_r;
   logic [W-1:0] sync_r;
   logic [W-1:0] prev_r;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         meta_r <= '0;
         sync_r <= '0;
         prev_r <= '0;
      end else begin
         meta_r <= async_in;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   assign level = sync_r ^ invert;
   assign lead  = level & ~(prev_r ^ invert);

endmodule

`default_nettype wire

// *** testbench/rvp_monitor.sv ***
/*
 * Register and mode checks of the video input port.
 * Assumes binding to rvp_port and full-word writes.
 */
`timescale 1ns/1ps
`default_nettype none

module rvp_monitor (
   // Clock and reset.
   input wire logic        clk,
   input wire logic        sys_rst,
   // Register bus.
   input wire logic [7:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   // Status.
   input wire logic        video_active
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);

   logic [7:0]  ctrl_r;
   logic [1:0]  age_r;
   logic [23:0] cxw_r;
   logic        ref_r;
   wire         done = !avs_waitrequest && (avs_read || avs_write);
   wire         rd_st = done && avs_read && avs_address == 8'h20;
   wire         capt = ctrl_r[0] && ctrl_r[2:1] == 2'b01 && ctrl_r[4:3] != 2'b11;

   ////////////////////////////////////////
   // Age lets the capture flag follow a control write.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl_r <= 8'h00;
         age_r  <= 2'h0;
      end else if (done && avs_write && avs_address == 8'h00 && avs_byteenable[0]) begin
         ctrl_r <= avs_writedata[7:0];
         age_r  <= 2'h0;
      end else if (age_r != 2'h3) begin
         age_r <= age_r + 2'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cxw_r <= 24'hEF0000;
      end else if (done && avs_write && avs_address == 8'h10 && !video_active) begin
         cxw_r <= avs_writedata[23:0];
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ref_r <= 1'b0;
      end else if (done && video_active && avs_address == 8'h1C) begin
         ref_r <= 1'b1;
      end else if (done && avs_write && avs_address == 8'h20 && avs_writedata[4]) begin
         ref_r <= 1'b0;
      end
   end

   sequence s_req;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence s_ans;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence

   property p_answer;
      s_req |=> s_ans;
   endproperty
   property p_mode_active;
      age_r == 2'h3 |-> video_active == capt;
   endproperty
   property p_vsync_mode;
      rd_st |-> avs_readdata[1] == (!ctrl_r[0] && ctrl_r[2:1] == 2'b10);
   endproperty
   property p_no_fast;
      rd_st && video_active |-> !avs_readdata[3];
   endproperty
   property p_bad_code;
      rd_st |-> avs_readdata[2] == (ctrl_r[2:1] == 2'b11 || ctrl_r[4:3] == 2'b11);
   endproperty
   property p_ram_blocked;
      done && avs_read && avs_address == 8'h1C && video_active |-> avs_readdata == 32'h0;
   endproperty
   property p_cpu_win;
      done && avs_read && avs_address == 8'h10 |->
         (avs_readdata[23:0] & 24'hFF00FF) == (cxw_r & 24'hFF00FF);
   endproperty
   property p_refused;
      rd_st |-> avs_readdata[4] == ref_r;
   endproperty

   a_answer: assert property (p_answer)
      else $error("access not answered in one cycle");
   a_mode_active: assert property (p_mode_active)
      else $error("capture flag wrong");
   a_vsync_mode: assert property (p_vsync_mode)
      else $error("frame locked flag wrong");
   a_no_fast: assert property (p_no_fast)
      else $error("fast write on in capture");
   a_bad_code: assert property (p_bad_code)
      else $error("prohibited code flag wrong");
   a_ram_blocked: assert property (p_ram_blocked)
      else $error("ram read served in capture");
   a_cpu_win: assert property (p_cpu_win)
      else $error("cpu window changed in capture");
   a_refused: assert property (p_refused)
      else $error("refused flag wrong");
endmodule

bind rvp_port rvp_monitor u_mon (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
   .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .video_active(video_active));

`default_nettype wire

// *** testbench/rvp_port_test.sv ***
/*
 * Self-checking bench of the video input port.
 * Assumes the source model and bound checker.
 */
`timescale 1ns/1ps
`default_nettype none

module rvp_port_test;
   typedef struct packed {logic [7:0] ctrl; logic [17:0] pix;} rvp_row_t;
   logic        clk, sys_rst, avs_read, avs_write, avs_waitrequest, video_active, act;
   logic [7:0]  avs_address, ctl;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic [3:0]  avs_byteenable;
   logic [17:0] mem [3];
   wire         hsync, vsync, dot_clock, vld;
   wire  [5:0]  red, green, blue;
   int          fail_count, n_checks;
   rvp_row_t    rows [7] = '{{8'h03, 18'h2A5C3}, {8'hE3, 18'h15A3C}, {8'h0B, 18'h20C61},
      {8'h13, 18'h1B2E4}, {8'h1B, 18'h0F0F0}, {8'h07, 18'h33333}, {8'h02, 18'h11111}};
   logic [39:0] rst_tab [8] = '{40'h0000000000, 40'h0400000001, 40'h0800EF0000,
      40'h0C013F0000, 40'h1000EF0000, 40'h14013F0000, 40'h1800000000, 40'h3C00000000};

   rvp_port #(.OSC_DIV(2)) dut (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .hsync(hsync), .vsync(vsync), .dot_clock(dot_clock),
      .valid_window_enable(vld), .rgb_red(red), .rgb_green(green), .rgb_blue(blue),
      .video_active(video_active));
   rvp_video_src src (.hsync(hsync), .vsync(vsync), .dot_clock(dot_clock),
      .valid_window_enable(vld), .rgb_red(red), .rgb_green(green), .rgb_blue(blue));

   ////////////////////////////////////////
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Waits an edge first so a dropped strobe is not raised again at once.
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      {avs_write, avs_read} <= {wr, !wr};
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 40);
      q = avs_readdata;
      {avs_write, avs_read} <= 2'b00;
      if (n >= 40) fail_count++;
   endtask

   function automatic logic [17:0] stored(input logic [1:0] w, input logic [17:0] v);
      return (w == 2'b01) ? {v[17:13], v[17], v[11:6], v[5:1], v[5]} : v;
   endfunction

   // Index 2 starts line 1, the others sit on line 0.
   task automatic ram_chk(input int i);
      bus(1'b1, 8'h18, (i == 2) ? 32'h0001_0000 : i);
      bus(1'b0, 8'h1C, 32'h0);
      check("ram", {14'h0, q[17:0]}, {14'h0, mem[i]});
   endtask

   task automatic frame(input logic [1:0] w, input logic [17:0] p);
      src.sync(1'b1);
      src.sync(1'b0);
      src.pixel(w, p);
      src.pixel(w, p + 18'h1);
      src.sync(1'b0);
      src.pixel(w, p + 18'h2);
      #400;
   endtask

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   initial begin
      #400000;
      fail_count++;
      final_report();
   end

   initial begin
      {sys_rst, avs_read, avs_write, avs_address, avs_writedata} = {1'b1, 42'h0};
      avs_byteenable = 4'hF;
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      bus(1'b1, 8'h04, 32'h0);
      foreach (rows[i]) begin
         ctl = rows[i].ctrl;
         act = ctl[0] && ctl[2:1] == 2'b01 && ctl[4:3] != 2'b11;
         bus(1'b1, 8'h00, {24'h0, ctl & 8'hE0});
         src.set_pol({ctl[5], ctl[6], ctl[7]});
         bus(1'b1, 8'h00, {24'h0, ctl});
         repeat (3) @(posedge clk);
         check("active", {31'h0, video_active}, {31'h0, act});
         frame(ctl[4:3], rows[i].pix);
         if (act) for (int k = 0; k < 3; k++) mem[k] = stored(ctl[4:3], rows[i].pix + k);
         bus(1'b1, 8'h00, {24'h0, ctl & 8'hE0});
         for (int k = 0; k < 3; k++) ram_chk(k);
      end
      bus(1'b1, 8'h00, 32'h4);
      src.sync(1'b1);
      bus(1'b0, 8'h28, 32'h0);
      check("scan", q, 32'h0);
      bus(1'b0, 8'h20, 32'h0);
      check("lockmode", q & 32'h2, 32'h2);
      bus(1'b1, 8'h04, 32'h11);
      bus(1'b1, 8'h00, 32'h103);
      src.sync(1'b1);
      src.sync(1'b0);
      src.sync(1'b0);
      src.pixel(2'b00, 18'h0);
      src.pixel(2'b00, 18'h3C3C3);
      src.valid_window_enable = 1'b0;
      src.pixel(2'b00, 18'h00FF0);
      src.valid_window_enable = 1'b1;
      mem[0] = 18'h3C3C3;
      bus(1'b1, 8'h10, 32'h0010_0005);
      bus(1'b0, 8'h10, 32'h0);
      check("cpuwin", q & 32'h00FF00FF, 32'h00EF0000);
      bus(1'b1, 8'h1C, 32'h12345);
      bus(1'b0, 8'h1C, 32'h0);
      check("ramblock", q, 32'h0);
      bus(1'b0, 8'h20, 32'h0);
      check("refused", q & 32'h10, 32'h10);
      check("fastoff", q & 32'h8, 32'h0);
      bus(1'b1, 8'h00, 32'h0);
      for (int k = 0; k < 3; k++) ram_chk(k);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      foreach (rst_tab[i]) begin
         bus(1'b0, rst_tab[i][39:32], 32'h0);
         check("reset", q, rst_tab[i][31:0]);
      end
      avs_byteenable <= 4'h0;
      bus(1'b1, 8'h04, 32'hFF);
      bus(1'b0, 8'h04, 32'h0);
      check("lanes", q, 32'h1);
      final_report();
   end
endmodule

`default_nettype wire

// *** testbench/rvp_video_src.sv ***
/*
 * Display controller model driving the video pins.
 * Assumes one task call at a time, polarity set first.
 */
`timescale 1ns/1ps
`default_nettype none

module rvp_video_src (
   // Sync, clock and window enable pins.
   output var logic       hsync,
   output var logic       vsync,
   output var logic       dot_clock,
   output var logic       valid_window_enable,
   // Pixel groups.
   output var logic [5:0] rgb_red,
   output var logic [5:0] rgb_green,
   output var logic [5:0] rgb_blue
);
   logic hs_inv, vs_inv, dot_inv;

   ////////////////////////////////////////
   initial begin
      set_pol(3'b000);
      valid_window_enable = 1'b1;
      {rgb_red, rgb_green, rgb_blue} = 18'h0;
   end

   // Idle levels follow polarity; the dot clock rests between pixels.
   task automatic set_pol(input logic [2:0] inv);
      {hs_inv, vs_inv, dot_inv} = inv;
      {hsync, vsync, dot_clock} = inv;
   endtask

   // Syncs never overlap, so no frame pulse falls in a line guard.
   task automatic sync(input logic frame);
      if (frame) vsync = !vs_inv; else hsync = !hs_inv;
      #400;
      if (frame) vsync = vs_inv; else hsync = hs_inv;
      #400;
   endtask

   // Data invert after each strobe so a stale word cannot pass.
   task automatic pixel(input logic [1:0] wid, input logic [17:0] v);
      int n;
      n = (wid == 2'b10) ? 3 : 1;
      for (int i = 0; i < n; i++) begin
         if (n == 3) {rgb_red, rgb_green, rgb_blue} = {v[17-6*i -: 6], ~rgb_green, ~rgb_blue};
         else {rgb_red, rgb_green, rgb_blue} = v;
         if (wid == 2'b01) {rgb_red[0], rgb_blue[0]} = {~v[12], ~v[0]};
         #100 dot_clock = !dot_inv;
         #100 dot_clock = dot_inv;
         {rgb_red, rgb_green, rgb_blue} = ~{rgb_red, rgb_green, rgb_blue};
      end
   endtask
endmodule

`default_nettype wire
